// ### cce_defs.vh
// Constants for the condition code evaluator and its register slave
`ifndef CCE_DEFS_VH
`define CCE_DEFS_VH

// Condition subcodes, low four bits appended to the main opcode
`define CCE_CODE_W 4
`define CCE_CC_OVF 4'h0
`define CCE_CC_NO_OVF 4'h1
`define CCE_CC_BELOW 4'h2
`define CCE_CC_NOT_BELOW 4'h3
`define CCE_CC_EQUAL 4'h4
`define CCE_CC_NOT_EQUAL 4'h5
`define CCE_CC_BELOW_EQ 4'h6
`define CCE_CC_ABOVE 4'h7
`define CCE_CC_SIGN 4'h8
`define CCE_CC_NO_SIGN 4'h9
`define CCE_CC_PARITY 4'ha
`define CCE_CC_NO_PARITY 4'hb
`define CCE_CC_LESS 4'hc
`define CCE_CC_GREATER_EQ 4'hd
`define CCE_CC_LESS_EQ 4'he
`define CCE_CC_GREATER 4'hf
// Alternate names for the same tests share one subcode
`define CCE_CC_NOT_ABOVE_NOR_EQ `CCE_CC_BELOW
`define CCE_CC_ABOVE_EQ `CCE_CC_NOT_BELOW
`define CCE_CC_ZERO `CCE_CC_EQUAL
`define CCE_CC_NOT_ZERO `CCE_CC_NOT_EQUAL
`define CCE_CC_NOT_ABOVE `CCE_CC_BELOW_EQ
`define CCE_CC_PARITY_EVEN `CCE_CC_PARITY
`define CCE_CC_PARITY_ODD `CCE_CC_NO_PARITY
`define CCE_CC_NOT_GREATER_EQ `CCE_CC_LESS
`define CCE_CC_NOT_LESS `CCE_CC_GREATER_EQ
`define COND_LESS_OR_EQUAL `CCE_CC_LESS_EQ
`define COND_NOT_GREATER `CCE_CC_LESS_EQ
`define CCE_NUM_CODES 16

// Flag vector layout
`define CCE_FLAG_W 5
`define CCE_FLAG_CARRY 0
`define CCE_FLAG_OVF 1
`define CCE_FLAG_SIGN 2
`define CCE_FLAG_ZERO 3
`define CCE_FLAG_PARITY 4

// Register byte offsets
`define CCE_ADDR_W 8
`define CCE_OFS_CTRL 8'h00
`define CCE_OFS_SW_FLAGS 8'h04
`define CCE_OFS_SW_CODE 8'h08
`define CCE_OFS_RESULT 8'h0c
`define CCE_OFS_VECTOR 8'h10
`define CCE_OFS_TRUE_CNT 8'h14
`define CCE_OFS_EVAL_CNT 8'h18

// Control register fields
`define CCE_CTRL_ENABLE 0
`define CCE_CTRL_SW_FLAGS 1
`define CCE_CTRL_SW_CODE 2
`define CCE_CTRL_W 3
`define CCE_CTRL_RST 3'h1

// Result register fields
`define CCE_RES_TRUE 0
`define CCE_RES_VALID 1
`define CCE_RES_CODE_LO 8
`define CCE_RES_FLAGS_LO 16

// Register select one-hot indices
`define CCE_SEL_W 7
`define CCE_SEL_CTRL 0
`define CCE_SEL_SW_FLAGS 1
`define CCE_SEL_SW_CODE 2
`define CCE_SEL_RESULT 3
`define CCE_SEL_VECTOR 4
`define CCE_SEL_TRUE_CNT 5
`define CCE_SEL_EVAL_CNT 6

`endif

// ### cce_eval.v
// Combinational evaluator of one condition subcode against the flags
`timescale 1ns/1ns
`include "cce_defs.vh"

module cce_eval (
    input wire [3:0] code,
    input wire [4:0] flags,
    output reg result
);

    wire cf;
    wire of;
    wire sf;
    wire zf;
    wire pf;
    wire lt;

    // Only the five status flags feed the
    assign cf = flags[`CCE_FLAG_CARRY];
    assign of = flags[`CCE_FLAG_OVF];
    assign sf = flags[`CCE_FLAG_SIGN];
    assign zf = flags[`CCE_FLAG_ZERO];
    assign pf = flags[`CCE_FLAG_PARITY];
    // Signed order comes from sign against overflow
    assign lt = sf ^ of;

    // Pure mux, no storage: valid in the same cycle as its inputs
    always @* begin
        case (code)
            `CCE_CC_OVF: result = of;
            `CCE_CC_NO_OVF: result = ~of;
            `CCE_CC_BELOW: result = cf;
            `CCE_CC_NOT_BELOW: result = ~cf;
            `CCE_CC_EQUAL: result = zf;
            `CCE_CC_NOT_EQUAL: result = ~zf;
            `CCE_CC_BELOW_EQ: result = cf | zf;
            `CCE_CC_ABOVE: result = ~(cf | zf);
            `CCE_CC_SIGN: result = sf;
            `CCE_CC_NO_SIGN: result = ~sf;
            `CCE_CC_PARITY: result = pf;
            `CCE_CC_NO_PARITY: result = ~pf;
            `CCE_CC_LESS: result = lt;
            `CCE_CC_GREATER_EQ: result = ~lt;
            `CCE_CC_LESS_EQ: result = lt | zf;
            `CCE_CC_GREATER: result = ~(lt | zf);
            default: result = 1'b0;
        endcase
    end

endmodule // cce_eval

// ### cce_top.v
// Condition code evaluator with an APB register slave
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "cce_defs.vh"

// Notes on behaviour
// - Tests use only carry, overflow, sign, zero, parity
// - Four-bit subcode selects one of sixteen tests
// - 0000 overflow set, 0001 overflow clear
// - 0100 zero set, 0101 zero clear
// - Sign set/clear 1000/1001, parity 1010/1011
// - 0010 carry set, 0011 carry clear
// - 0110 carry or zero, 0111 neither
// - 1100 sign differs overflow, 1101 equal
// - 1110 sign differs overflow, or zero
// - 1111 sign equals overflow and zero clear
// - Alternate names share subcode and result
// - Above and below use carry, zero
// - Greater and less use sign, overflow, zero

module cce_top #(
    parameter ADDR_W = `CCE_ADDR_W,
    parameter CNT_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] subcode_in,
    input wire cond_req,
    input wire carry_flag,
    input wire overflow_flag,
    input wire sign_flag,
    input wire zero_flag,
    input wire parity_flag,
    output wire cond_true_q,
    output wire cond_valid_q,
    output wire [`CCE_NUM_CODES-1:0] cond_vector_q
);

    // Slave handshake states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg pready_q;
    reg pslverr_q;
    reg [31:0] prdata_q;
    reg [`CCE_CTRL_W-1:0] ctrl_q;
    reg [`CCE_FLAG_W-1:0] sw_flags_q;
    reg [3:0] sw_code_q;
    reg res_true_q;
    reg res_valid_q;
    reg [3:0] res_code_q;
    reg [`CCE_FLAG_W-1:0] res_flags_q;
    reg [`CCE_NUM_CODES-1:0] vector_q;
    reg [CNT_W-1:0] true_cnt_q;
    reg [CNT_W-1:0] true_cnt_d;
    reg [CNT_W-1:0] eval_cnt_q;
    reg [CNT_W-1:0] eval_cnt_d;
    reg [31:0] rdata_d;

    wire [`CCE_FLAG_W-1:0] pin_flags;
    wire [`CCE_FLAG_W-1:0] eff_flags;
    wire [3:0] eff_code;
    wire eff_result;
    wire [`CCE_NUM_CODES-1:0] all_results;
    wire [`CCE_SEL_W-1:0] sel;
    wire setup;
    wire wr_fire;
    wire eval_fire;
    wire enabled;

    // Decodes a byte address into a one-hot register select
    function [`CCE_SEL_W-1:0] reg_select;
        input [ADDR_W-1:0] addr;
        begin
            reg_select = {`CCE_SEL_W{1'b0}};
            case (addr)
                `CCE_OFS_CTRL: reg_select[`CCE_SEL_CTRL] = 1'b1;
                `CCE_OFS_SW_FLAGS: reg_select[`CCE_SEL_SW_FLAGS] = 1'b1;
                `CCE_OFS_SW_CODE: reg_select[`CCE_SEL_SW_CODE] = 1'b1;
                `CCE_OFS_RESULT: reg_select[`CCE_SEL_RESULT] = 1'b1;
                `CCE_OFS_VECTOR: reg_select[`CCE_SEL_VECTOR] = 1'b1;
                `CCE_OFS_TRUE_CNT: reg_select[`CCE_SEL_TRUE_CNT] = 1'b1;
                `CCE_OFS_EVAL_CNT: reg_select[`CCE_SEL_EVAL_CNT] = 1'b1;
                default: reg_select = {`CCE_SEL_W{1'b0}};
            endcase
        end
    endfunction

    // True when an address hits a register that software may write
    function writable;
        input [`CCE_SEL_W-1:0] s;
        begin
            writable = s[`CCE_SEL_CTRL] | s[`CCE_SEL_SW_FLAGS] |
                       s[`CCE_SEL_SW_CODE] | s[`CCE_SEL_TRUE_CNT] |
                       s[`CCE_SEL_EVAL_CNT];
        end
    endfunction

    // Gather the pin flags into one vector
    assign pin_flags = {parity_flag, zero_flag, sign_flag,
                        overflow_flag, carry_flag};

    // Software may replace flags or code, handy for bring-up checks
    assign eff_flags = ctrl_q[`CCE_CTRL_SW_FLAGS] ? sw_flags_q : pin_flags;
    assign eff_code = ctrl_q[`CCE_CTRL_SW_CODE] ? sw_code_q : subcode_in;
    assign enabled = ctrl_q[`CCE_CTRL_ENABLE];

    // Evaluator for the selected subcode
    cce_eval u_eval (
        .code(eff_code),
        .flags(eff_flags),
        .result(eff_result)
    );

    // One evaluator per subcode gives a full view of all sixteen tests
    genvar gi;
    generate
        for (gi = 0; gi < `CCE_NUM_CODES; gi = gi + 1) begin : g_all
            // A genvar cannot be part-selected, so size it here
            localparam [`CCE_CODE_W-1:0] ONE_CODE = gi;
            cce_eval u_one (
                .code(ONE_CODE),
                .flags(eff_flags),
                .result(all_results[gi])
            );
        end
    endgenerate

    // APB phases
    assign sel = reg_select(paddr);
    assign setup = psel & ~penable;
    assign wr_fire = psel & penable & pready_q & pwrite;
    // Evaluation needs a request from the decoder, or software forcing
    assign eval_fire = enabled & (cond_req | ctrl_q[`CCE_CTRL_SW_CODE]);

    // Next state of the slave handshake
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (setup) begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Read data mux, sampled during setup so it stands in the access phase
    always @* begin
        rdata_d = 32'h0000_0000;
        if (sel[`CCE_SEL_CTRL]) begin
            rdata_d[`CCE_CTRL_W-1:0] = ctrl_q;
        end
        if (sel[`CCE_SEL_SW_FLAGS]) begin
            rdata_d[`CCE_FLAG_W-1:0] = sw_flags_q;
        end
        if (sel[`CCE_SEL_SW_CODE]) begin
            rdata_d[3:0] = sw_code_q;
        end
        if (sel[`CCE_SEL_RESULT]) begin
            rdata_d[`CCE_RES_TRUE] = res_true_q;
            rdata_d[`CCE_RES_VALID] = res_valid_q;
            rdata_d[`CCE_RES_CODE_LO+3:`CCE_RES_CODE_LO] = res_code_q;
            rdata_d[`CCE_RES_FLAGS_LO+`CCE_FLAG_W-1:`CCE_RES_FLAGS_LO] =
                res_flags_q;
        end
        if (sel[`CCE_SEL_VECTOR]) begin
            rdata_d[`CCE_NUM_CODES-1:0] = vector_q;
        end
        if (sel[`CCE_SEL_TRUE_CNT]) begin
            rdata_d[CNT_W-1:0] = true_cnt_q;
        end
        if (sel[`CCE_SEL_EVAL_CNT]) begin
            rdata_d[CNT_W-1:0] = eval_cnt_q;
        end
    end

    // Handshake and answer registers; zero wait states after setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            if (state_q == ST_IDLE && setup) begin
                pready_q <= 1'b1;
                // Unmapped, or a write to a read-only register, errors
                pslverr_q <= pwrite ? ~writable(sel) : ~(|sel);
                prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
            end else if (state_q == ST_ACK) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // Software-written control and override registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `CCE_CTRL_RST;
            sw_flags_q <= {`CCE_FLAG_W{1'b0}};
            sw_code_q <= 4'h0;
        end else if (wr_fire) begin
            if (sel[`CCE_SEL_CTRL]) begin
                ctrl_q <= pwdata[`CCE_CTRL_W-1:0];
            end
            if (sel[`CCE_SEL_SW_FLAGS]) begin
                sw_flags_q <= pwdata[`CCE_FLAG_W-1:0];
            end
            if (sel[`CCE_SEL_SW_CODE]) begin
                sw_code_q <= pwdata[3:0];
            end
        end
    end

    // Capture each evaluation for the consumer and for software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_true_q <= 1'b0;
            res_valid_q <= 1'b0;
            res_code_q <= 4'h0;
            res_flags_q <= {`CCE_FLAG_W{1'b0}};
        end else begin
            res_valid_q <= eval_fire;
            if (eval_fire) begin
                res_true_q <= eff_result;
                res_code_q <= eff_code;
                res_flags_q <= eff_flags;
            end
        end
    end

    // All sixteen results follow the flags every cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_q <= {`CCE_NUM_CODES{1'b0}};
        end else begin
            vector_q <= all_results;
        end
    end

    // Counters: an evaluation in the clearing cycle still counts once
    always @* begin
        true_cnt_d = true_cnt_q;
        eval_cnt_d = eval_cnt_q;
        if (wr_fire && sel[`CCE_SEL_TRUE_CNT]) begin
            true_cnt_d = {CNT_W{1'b0}};
        end
        if (wr_fire && sel[`CCE_SEL_EVAL_CNT]) begin
            eval_cnt_d = {CNT_W{1'b0}};
        end
        if (eval_fire) begin
            eval_cnt_d = eval_cnt_d + {{(CNT_W-1){1'b0}}, 1'b1};
            if (eff_result) begin
                true_cnt_d = true_cnt_d + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Counter storage; wraps silently, software reads and clears
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            true_cnt_q <= {CNT_W{1'b0}};
            eval_cnt_q <= {CNT_W{1'b0}};
        end else begin
            true_cnt_q <= true_cnt_d;
            eval_cnt_q <= eval_cnt_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign cond_true_q = res_true_q;
    assign cond_valid_q = res_valid_q;
    assign cond_vector_q = vector_q;

endmodule // cce_top

// ### cce_src.sv
// Behavioural decoder and flag source at the evaluator's far side
`timescale 1ns/1ns
module cce_src (
    input wire pclk,
    input wire go,
    output reg [3:0] subcode_in,
    output reg cond_req,
    output reg [4:0] flags
);
    integer seed = 49548;
    integer r;
    initial begin
        subcode_in = 4'h0;
        cond_req = 1'b0;
        flags = 5'h0;
    end
    // New code and flags every cycle; request gaps model a slow decoder
    always @(posedge pclk) begin
        r = $random(seed);
        subcode_in <= r[3:0];
        flags <= r[8:4];
        cond_req <= go && (r[10:9] != 2'h0);
    end
endmodule // cce_src

// ### cce_top_chk.sv
// Port checker for the condition code evaluator
`timescale 1ns/1ns
module cce_top_chk #(
    parameter ADDR_W = 8,
    parameter CNT_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire pready,
    input wire [3:0] subcode_in,
    input wire cond_req,
    input wire carry_flag,
    input wire overflow_flag,
    input wire sign_flag,
    input wire zero_flag,
    input wire parity_flag,
    input wire cond_true_q,
    input wire cond_valid_q,
    input wire [15:0] cond_vector_q
);
    reg [2:0] ctl_q;
    reg [4:0] swf_q;
    reg [15:0] vec_q;
    integer i;
    // Software code mode evaluates every cycle; pin checks need both off
    wire take = ctl_q[0] && (cond_req || ctl_q[2]);
    wire pin = !ctl_q[1] && !ctl_q[2];
    wire c0 = subcode_in[0];
    wire sx = sign_flag ^ overflow_flag;
    wire sxz = sx | zero_flag;
    wire cz = carry_flag | zero_flag;
    wire sp = subcode_in[1] ? parity_flag : sign_flag;
    wire [4:0] fl = ctl_q[1] ? swf_q : {parity_flag, zero_flag, sign_flag,
        overflow_flag, carry_flag};
    // Truth of one subcode; flags packed carry, ovf, sign, zero, parity
    function automatic logic ev(input [3:0] c, input [4:0] f);
        reg b;
        begin
            case (c[3:1])
                3'h0: b = f[1];
                3'h1: b = f[0];
                3'h2: b = f[3];
                3'h3: b = f[0] | f[3];
                3'h4: b = f[2];
                3'h5: b = f[4];
                3'h6: b = f[2] ^ f[1];
                default: b = (f[2] ^ f[1]) | f[3];
            endcase
            ev = b ^ c[0];
        end
    endfunction
    // Control and software flags mirror the register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= 3'h1;
            swf_q <= 5'h0;
            vec_q <= 16'h0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 8'h00)
                ctl_q <= pwdata[2:0];
            if (psel && penable && pready && pwrite && paddr == 8'h04)
                swf_q <= pwdata[4:0];
            for (i = 0; i < 16; i = i + 1)
                vec_q[i] <= ev(i[3:0], fl);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_taken; take |=> cond_valid_q; endproperty
    a_taken: assert property (p_taken) else $error("no valid");
    property p_idle; !take |=> !cond_valid_q && $stable(cond_true_q);
    endproperty
    a_idle: assert property (p_idle) else $error("spurious");
    property p_ovf; take && pin && subcode_in[3:1] == 3'h0 |=>
        cond_true_q == ($past(overflow_flag) ^ $past(c0)); endproperty
    a_ovf: assert property (p_ovf) else $error("ovf test");
    property p_carry; take && pin && subcode_in[3:1] == 3'h1 |=>
        cond_true_q == ($past(carry_flag) ^ $past(c0)); endproperty
    a_carry: assert property (p_carry) else $error("carry");
    property p_zero; take && pin && subcode_in[3:1] == 3'h2 |=>
        cond_true_q == ($past(zero_flag) ^ $past(c0)); endproperty
    a_zero: assert property (p_zero) else $error("zero");
    property p_beq; take && pin && subcode_in[3:1] == 3'h3 |=>
        cond_true_q == ($past(cz) ^ $past(c0)); endproperty
    a_beq: assert property (p_beq) else $error("below eq");
    property p_sp; take && pin && subcode_in[3:2] == 2'h2 |=>
        cond_true_q == ($past(sp) ^ $past(c0)); endproperty
    a_sp: assert property (p_sp) else $error("sign par");
    property p_less; take && pin && subcode_in[3:1] == 3'h6 |=>
        cond_true_q == ($past(sx) ^ $past(c0)); endproperty
    a_less: assert property (p_less) else $error("less");
    property p_le; take && pin && subcode_in[3:1] == 3'h7 |=>
        cond_true_q == ($past(sxz) ^ $past(c0)); endproperty
    a_le: assert property (p_le) else $error("less eq");
    property p_vec; cond_vector_q == vec_q; endproperty
    a_vec: assert property (p_vec) else $error("vector");
    property p_apb; psel && !penable |=> pready ##1 !pready; endproperty
    a_apb: assert property (p_apb) else $error("pready");
    c_gt: cover property (take && subcode_in == 4'hf);
    c_off: cover property (!ctl_q[0] && cond_req);
    c_wr: cover property (psel && penable && pready && pwrite);
endmodule // cce_top_chk
bind cce_top cce_top_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) cce_top_chk_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
    .subcode_in(subcode_in), .cond_req(cond_req), .carry_flag(carry_flag),
    .overflow_flag(overflow_flag), .sign_flag(sign_flag),
    .zero_flag(zero_flag), .parity_flag(parity_flag),
    .cond_true_q(cond_true_q), .cond_valid_q(cond_valid_q),
    .cond_vector_q(cond_vector_q));

// ### testbench.sv
// Self-checking bench for the condition code evaluator
`timescale 1ns/1ns
`include "cce_defs.vh"
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin \
    fail_count = fail_count + 1; \
    $display("Error at %0t: got %h want %h", $time, a, b); end end
module testbench;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg [7:0] paddr = 8'h0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [31:0] pwdata = 32'h0;
    reg go = 1'b0;
    reg [31:0] rd;
    reg err;
    wire [31:0] prdata;
    wire pready, pslverr, cond_req, cond_true_q, cond_valid_q;
    wire [3:0] subcode_in;
    wire [4:0] flg;
    wire [15:0] cond_vector_q;
    integer fail_count = 0, compares = 0, i;
    integer m_ctl = 1, m_swf = 0, m_swc = 0;
    integer m_val = 0, m_true = 0, m_code = 0, m_flags = 0;
    integer m_vec = 0, n_eval = 0, n_true = 0;
    cce_top #(.ADDR_W(8), .CNT_W(32)) cce_top_i (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .subcode_in(subcode_in), .cond_req(cond_req),
        .carry_flag(flg[0]), .overflow_flag(flg[1]), .sign_flag(flg[2]),
        .zero_flag(flg[3]), .parity_flag(flg[4]), .cond_true_q(cond_true_q),
        .cond_valid_q(cond_valid_q), .cond_vector_q(cond_vector_q));
    cce_src cce_src_i (.pclk(pclk), .go(go), .subcode_in(subcode_in),
        .cond_req(cond_req), .flags(flg));
    always #10 pclk = ~pclk;
    // Integer model of one test: carry, ovf, sign, zero, parity bits
    function integer ref_ev(input integer c, input integer f);
        integer b;
        begin
            case (c / 2)
                0: b = f >> 1;
                1: b = f;
                2: b = f >> 3;
                3: b = f | (f >> 3);
                4: b = f >> 2;
                5: b = f >> 4;
                6: b = (f >> 2) ^ (f >> 1);
                default: b = ((f >> 2) ^ (f >> 1)) | (f >> 3);
            endcase
            ref_ev = (b ^ c) & 1;
        end
    endfunction
    task tally_and_finish;
        begin
            $display("Mismatches %0d, compares %0d", fail_count, compares);
            if (fail_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // One APB transfer; the wait for pready is bounded
    task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                n = n + 1;
                @(posedge pclk);
            end
            if (n == 20) begin
                fail_count = fail_count + 1;
                tally_and_finish;
            end
            rd = prdata;
            err = pslverr;
            // Model registers change at the edge where the write lands
            if (w && a == `CCE_OFS_CTRL) m_ctl = d;
            if (w && a == `CCE_OFS_SW_FLAGS) m_swf = d;
            if (w && a == `CCE_OFS_SW_CODE) m_swc = d;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    // Mid-cycle: outputs settled, inputs for the next edge already set
    always @(negedge pclk) begin
        if (presetn) begin
            `CHK(cond_valid_q, m_val[0])
            `CHK(cond_true_q, m_true[0])
            `CHK(cond_vector_q, m_vec[15:0])
            m_val = m_ctl[0] & (cond_req | m_ctl[2]);
            if (m_val) begin
                m_code = m_ctl[2] ? m_swc : subcode_in;
                m_flags = m_ctl[1] ? m_swf : flg;
                m_true = ref_ev(m_code, m_flags);
                n_eval = n_eval + 1;
                n_true = n_true + m_true;
            end
            for (i = 0; i < 16; i = i + 1)
                m_vec[i] = ref_ev(i, m_ctl[1] ? m_swf : flg);
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `CCE_OFS_CTRL, 32'h0);
        `CHK(rd, 32'h1)
        go <= 1'b1;
        repeat (400) @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, `CCE_OFS_EVAL_CNT, 32'h0);
        `CHK(rd, n_eval)
        apb(1'b0, `CCE_OFS_TRUE_CNT, 32'h0);
        `CHK(rd, n_true)
        apb(1'b0, `CCE_OFS_RESULT, 32'h0);
        `CHK(rd, m_true | (m_code << 8) | (m_flags << 16))
        // Read-only and unmapped places are refused
        apb(1'b1, `CCE_OFS_RESULT, 32'hffffffff);
        `CHK(err, 1'b1)
        apb(1'b0, 8'h1c, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        // Disabled evaluator ignores requests; counter write clears
        apb(1'b1, `CCE_OFS_EVAL_CNT, 32'h0);
        apb(1'b1, `CCE_OFS_CTRL, 32'h0);
        go <= 1'b1;
        repeat (50) @(posedge pclk);
        go <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, `CCE_OFS_EVAL_CNT, 32'h0);
        `CHK(rd, 32'h0)
        // Software flags and code: zero set, equal test, runs every cycle
        apb(1'b1, `CCE_OFS_SW_FLAGS, 32'h8);
        apb(1'b1, `CCE_OFS_SW_CODE, 32'h4);
        apb(1'b1, `CCE_OFS_CTRL, 32'h7);
        repeat (5) @(posedge pclk);
        apb(1'b0, `CCE_OFS_RESULT, 32'h0);
        `CHK(rd, m_true | (m_val << 1) | (m_code << 8) | (m_flags << 16))
        `CHK(rd, 32'h0008_0403)
        tally_and_finish;
    end
endmodule // testbench
